// >>> bench/psr_dev_model.sv
// behavioural model of the pseudo-static ram driven by the host controller
`timescale 1ns/1ps
`include "psr_map.svh"
module psr_dev_model (
  input wire logic sel_hi_i,
  input wire logic cs_n_i,
  input wire logic adv_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic ub_n_i,
  input wire logic lb_n_i,
  input wire logic [22:0] addr_i,
  input wire logic [15:0] bus_i,
  input wire logic [1:0] pd_option_i,
  output logic [15:0] dev_data_o,
  output logic [1:0] dev_oe_o
);
  logic [15:0] mem [int]; // sparse array contents
  logic [22:0] lat_addr = 23'h000000; // address held by the strobe
  logic [22:0] eff_addr;
  logic [15:0] tmp;
  logic sel;
  int lost[$]; // words dropped by a power down
  assign sel = sel_hi_i && !cs_n_i;
  assign eff_addr = adv_n_i ? lat_addr : addr_i;
  always @(posedge adv_n_i) lat_addr = addr_i;
  // read path; unknown words give an address-made pattern, never zero
  always @*
  begin
    dev_oe_o = 2'h0;
    dev_data_o = mem.exists(eff_addr) ? mem[eff_addr] : {eff_addr[7:0], ~eff_addr[7:0]};
    if (sel && we_n_i && !oe_n_i)
      dev_oe_o = ~{ub_n_i, lb_n_i};
  end
  // write path; waits a moment so a latching edge at the same time lands first
  always
  begin
    @(negedge we_n_i);
    #1;
    if (sel)
    begin
      tmp = mem.exists(eff_addr) ? mem[eff_addr] : 16'h0000;
      if (!ub_n_i) tmp[15:8] = bus_i[15:8];
      if (!lb_n_i) tmp[7:0] = bus_i[7:0];
      mem[eff_addr] = tmp;
    end
  end
  // power down keeps only the chosen partial region
  always @(negedge sel_hi_i)
  begin
    lost = {};
    foreach (mem[k])
      if (pd_option_i == 2'h0 || k >= (pd_option_i == 2'h1 ? (1 << `PSR_PART16_LOG2)
          : (1 << `PSR_PART32_LOG2))) lost.push_back(k);
    foreach (lost[i]) mem.delete(lost[i]);
  end
endmodule

// >>> bench/psr_host_chk.sv
// pin-level checker for the pseudo-static ram host controller
`timescale 1ns/1ps
module psr_host_chk #(
  parameter int ADDR_W = 23
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic pd_req_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic powered_down_o,
  input wire logic select_high_active_o,
  input wire logic chip_select_n_o,
  input wire logic address_valid_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic output_strobe_n_o,
  input wire logic upper_lane_enable_n_o,
  input wire logic lower_lane_enable_n_o,
  input wire logic [ADDR_W-1:0] word_address_lines_o,
  input wire logic [1:0] data_oe_o
);
  // ****
  // idle-selected timer
  // ****
  localparam int IDLE_MAX = 40000; // one millisecond of 25 ns clocks
  logic [15:0] idle_reg; // cycles selected with both strobes off
  logic [15:0] idle_next;
  // restarts whenever a strobe is active or the device is let go
  always_comb
  begin
    idle_next = 16'h0000;
    if (select_high_active_o && !chip_select_n_o && write_strobe_n_o && output_strobe_n_o)
      idle_next = idle_reg + 16'h0001;
  end
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      idle_reg <= 16'h0000;
    else
      idle_reg <= idle_next;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence take_s;
    req_valid_i && req_ready_o && !pd_req_i;
  endsequence
  sequence take_rd_s;
    take_s ##0 !req_write_i;
  endsequence
  sequence take_wr_s;
    take_s ##0 req_write_i;
  endsequence
  AST_RD_LAT: assert property (take_rd_s |-> ##5 rsp_valid_o)
    else $error("first read word not on time");
  AST_WR_DONE: assert property (take_wr_s |-> ##1 (!req_ready_o)[*5] ##1 req_ready_o)
    else $error("write length wrong");
  AST_STROBE_EXCL: assert property (!(!output_strobe_n_o && !write_strobe_n_o))
    else $error("both strobes low");
  AST_IDLE_SEL: assert property (idle_reg < IDLE_MAX)
    else $error("selected idle too long");
  AST_PD_FLOAT: assert property (!select_high_active_o |-> data_oe_o == 2'h0)
    else $error("data driven in power down");
  AST_PD_ENTRY: assert property ($fell(select_high_active_o) |-> $past(chip_select_n_o))
    else $error("power down not from standby");
  AST_PD_FLAG: assert property (powered_down_o == !select_high_active_o)
    else $error("power down flag wrong");
  // a power-down request seen in idle must drop the select at the very next edge
  AST_PD_NEXT: assert property (pd_req_i && req_ready_o |=> !select_high_active_o)
    else $error("power down not entered on time");
  AST_ADDR_SET: assert property (($fell(output_strobe_n_o) || $fell(write_strobe_n_o))
    |-> $stable(word_address_lines_o) && !chip_select_n_o)
    else $error("address not set before strobe");
  AST_PAGE_HI: assert property (!output_strobe_n_o && !$past(output_strobe_n_o)
    |-> $stable(word_address_lines_o[ADDR_W-1:3]))
    else $error("page address left the page");
  AST_WR_LANES: assert property (!write_strobe_n_o
    |-> data_oe_o == ~{upper_lane_enable_n_o, lower_lane_enable_n_o})
    else $error("write lanes mismatch");
  AST_LATCH: assert property ($rose(address_valid_strobe_n_o) && !chip_select_n_o
    |-> $stable(word_address_lines_o))
    else $error("address moved at latch edge");
  AST_WR_END: assert property ($rose(write_strobe_n_o)
    |-> $rose(chip_select_n_o) && data_oe_o == 2'h0)
    else $error("write end not clean");
endmodule

bind psr_host_ctrl psr_host_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .req_valid_i(req_valid_i), .req_write_i(req_write_i), .pd_req_i(pd_req_i),
  .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .powered_down_o(powered_down_o),
  .select_high_active_o(select_high_active_o), .chip_select_n_o(chip_select_n_o),
  .address_valid_strobe_n_o(address_valid_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
  .output_strobe_n_o(output_strobe_n_o), .upper_lane_enable_n_o(upper_lane_enable_n_o),
  .lower_lane_enable_n_o(lower_lane_enable_n_o), .data_oe_o(data_oe_o),
  .word_address_lines_o(word_address_lines_o));

// >>> bench/test_psram_async_page_interface.sv
// self-checking testbench for the pseudo-static ram host controller
`timescale 1ns/1ps
`include "psr_map.svh"
module test_psram_async_page_interface;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic latch_mode_i = 1'b0;
  logic pd_req_i = 1'b0;
  logic [22:0] req_addr_i = 23'h000000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [1:0] req_lane_en_i = 2'h0;
  logic [1:0] pd_option_i = 2'h0;
  logic [2:0] req_page_extra_i = 3'h0;
  logic [15:0] data_i, bus_last = 16'h0000, dev_d, rd, dout;
  logic [1:0] doe, dev_oe;
  logic rdy, rv, st, pdn, shi, cs_n, adv_n, we_n, oe_n, ub_n, lb_n;
  logic [22:0] wa;
  logic [15:0] ref_mem [int]; // expected array contents
  logic [15:0] exp_d[$]; // expected read words in order
  logic exp_s[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int pd_log = -1; // log2 of the region kept by the last power down, 0 none kept, -1 none since reset
  localparam logic [22:0] PD_A [3] = '{23'h000010, 23'h180000, 23'h400000};

  psr_host_ctrl uut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_lane_en_i(req_lane_en_i), .req_page_extra_i(req_page_extra_i),
    .latch_mode_i(latch_mode_i), .pd_req_i(pd_req_i), .pd_option_i(pd_option_i),
    .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rd), .rsp_stale_o(st),
    .powered_down_o(pdn), .select_high_active_o(shi), .chip_select_n_o(cs_n),
    .address_valid_strobe_n_o(adv_n), .write_strobe_n_o(we_n), .output_strobe_n_o(oe_n),
    .upper_lane_enable_n_o(ub_n), .lower_lane_enable_n_o(lb_n), .word_address_lines_o(wa),
    .data_o(dout), .data_oe_o(doe), .data_i(data_i));
  psr_dev_model u_dev (.sel_hi_i(shi), .cs_n_i(cs_n), .adv_n_i(adv_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .ub_n_i(ub_n), .lb_n_i(lb_n), .addr_i(wa), .bus_i(data_i),
    .pd_option_i(pd_option_i), .dev_data_o(dev_d), .dev_oe_o(dev_oe));

  always #12.5 clk_i = ~clk_i;
  // bus per lane: host, then device, else the inverse of the last level
  always_comb
    for (int i = 0; i < 16; i++)
      data_i[i] = doe[i/8] ? dout[i] : (dev_oe[i/8] ? dev_d[i] : ~bus_last[i]);
  always @(posedge clk_i) bus_last <= data_i;
  // cut a hang short
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // every read word against the bench model; lost words have no data
  always @(negedge clk_i)
    if (rv === 1'b1)
    begin
      check("rsp_count", exp_d.size() > 0, 1'b1);
      if (!exp_s[0]) check("rdata", rd, exp_d[0]);
      check("stale", st, exp_s[0]);
      void'(exp_d.pop_front());
      void'(exp_s.pop_front());
    end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // one access, held until the design takes it
  task automatic access(input logic wr, input logic [22:0] a, input logic [15:0] d,
                        input logic [1:0] ln, input logic [2:0] ex);
    logic [15:0] m;
    logic [22:0] pa;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_lane_en_i <= ln;
    req_page_extra_i <= ex;
    #1;
    while (rdy !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    if (wr)
      ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] & ~m : 16'h0000) | (d & m);
    else
      for (int k = 0; k <= ex; k++)
      begin
        pa = {a[22:3], a[2:0] + k[2:0]};
        exp_d.push_back(ref_mem[pa] & m);
        exp_s.push_back(pd_log >= 0 && (pd_log == 0 || pa >= (1 << pd_log)));
      end
  endtask

  task automatic wait_idle();
    @(posedge clk_i);
    #1;
    while (rdy !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
    end
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    pd_log = -1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    logic [22:0] b;
    void'($urandom(18));
    do_reset();
    // lanes, pages and back to back, in both addressing modes
    for (int lm = 0; lm < 2; lm++)
    begin
      wait_idle();
      @(posedge clk_i);
      latch_mode_i <= lm[0];
      b = 23'($urandom) & 23'h7FFFF8;
      for (int k = 0; k < 8; k++) access(1'b1, b + 23'(k), 16'($urandom), 2'h3, 3'h0);
      for (int k = 0; k < 4; k++) access(1'b1, b + 23'(k), 16'($urandom), 2'(k), 3'h0);
      for (int k = 0; k < 4; k++) access(1'b0, b + 23'(k), 16'h0000, 2'(k), 3'h0);
      access(1'b0, b + 23'h000005, 16'h0000, 2'h3, 3'h7);
      access(1'b0, b + 23'h000003, 16'h0000, 2'(lm + 1), 3'h2);
      access(1'b1, b + 23'h000002, 16'($urandom), 2'h3, 3'h0);
      access(1'b0, b + 23'h000002, 16'h0000, 2'h3, 3'h0);
      $display("test lanes and pages done, mode %0d", lm);
    end
    // each power-down option, then reads inside and outside its region
    for (int o = 0; o < 3; o++)
    begin
      wait_idle();
      do_reset();
      foreach (PD_A[i]) access(1'b1, PD_A[i], 16'($urandom), 2'h3, 3'h0);
      wait_idle();
      @(posedge clk_i);
      pd_option_i <= 2'(o);
      pd_req_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      check("sel_hi", shi, 1'b0);
      check("pd_flag", pdn, 1'b1);
      check("dev_oe", dev_oe, 2'h0);
      @(posedge clk_i);
      pd_req_i <= 1'b0;
      pd_log = (o == 0) ? 0 : ((o == 1) ? `PSR_PART16_LOG2 : `PSR_PART32_LOG2);
      foreach (PD_A[i]) access(1'b0, PD_A[i], 16'h0000, 2'h3, 3'h0);
      $display("test power down done, option %0d", o);
    end
    wait_idle();
    check("rsp_left", exp_d.size(), 0);
    end_sim();
  end
endmodule

// >>> hdl/psr_host_ctrl.sv
// host-side controller driving a pseudo-static ram in asynchronous page mode
`timescale 1ns/1ps
`include "psr_map.svh"

// Summary of operation
// - address strobe low passes, rising edge latches
// - never idle-selected over one millisecond
// - power down only from standby, data floats
// - output strobe held high through writes
// - address valid before any read or write
module psr_host_ctrl #(
  parameter int ADDR_W = 23,
  parameter int DATA_W = 16,
  parameter int T_WP_NS = 70,
  parameter int T_RECOVER_NS = 25
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [1:0] req_lane_en_i,
  input wire logic [2:0] req_page_extra_i,
  input wire logic latch_mode_i,
  input wire logic pd_req_i,
  input wire logic [1:0] pd_option_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  output logic rsp_stale_o,
  output logic powered_down_o,
  output logic select_high_active_o,
  output logic chip_select_n_o,
  output logic address_valid_strobe_n_o,
  output logic write_strobe_n_o,
  output logic output_strobe_n_o,
  output logic upper_lane_enable_n_o,
  output logic lower_lane_enable_n_o,
  output logic [ADDR_W-1:0] word_address_lines_o,
  output logic [DATA_W-1:0] data_o,
  output logic [1:0] data_oe_o,
  input wire logic [DATA_W-1:0] data_i
);

  // ************************************************************
  // phase lengths in cycles
  // ************************************************************
  localparam logic [`PSR_TMR_W-1:0] CE_CYC = psr_pkg::psr_ns_to_cycles(`PSR_T_CE_NS);
  localparam logic [`PSR_TMR_W-1:0] PAA_CYC = psr_pkg::psr_ns_to_cycles(`PSR_T_PAA_NS);
  localparam logic [`PSR_TMR_W-1:0] WP_CYC = psr_pkg::psr_ns_to_cycles(T_WP_NS);
  localparam logic [`PSR_TMR_W-1:0] REC_CYC = psr_pkg::psr_ns_to_cycles(T_RECOVER_NS);
  localparam logic [`PSR_TMR_W-1:0] ONE_CYC = `PSR_TMR_W'(1);

  // ************************************************************
  // state
  // ************************************************************
  psr_pkg::psr_state_t state_reg, state_next; // sequencer
  psr_pkg::psr_pd_opt_t pd_opt_reg, pd_opt_next; // option of last power down
  logic write_reg, write_next; // access is a write
  logic latch_reg, latch_next; // access uses latched addressing
  logic lost_reg, lost_next; // a power down has happened
  logic [2:0] left_reg, left_next; // page words still to read
  logic [1:0] lane_reg, lane_next; // enabled byte lanes, bit1 upper
  logic ready_reg, ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic stale_reg, stale_next;
  logic sel_hi_reg, sel_hi_next;
  logic pdn_reg, pdn_next; // power-down flag, kept in its own flop for the output
  logic cs_n_reg, cs_n_next;
  logic adv_n_reg, adv_n_next;
  logic we_n_reg, we_n_next;
  logic oe_n_reg, oe_n_next;
  logic [1:0] lane_n_reg, lane_n_next; // lane enables as driven, active low
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic [1:0] doe_reg, doe_next;
  logic tmr_load; // start a timed phase
  logic [`PSR_TMR_W-1:0] tmr_cycles;
  logic tmr_done;

  // ************************************************************
  // helpers
  // ************************************************************
  // true when the word survives the chosen power-down option
  function automatic logic in_retained(input logic [ADDR_W-1:0] a,
                                       input psr_pkg::psr_pd_opt_t o);
    logic r;
    r = 1'b0;
    case (o)
      psr_pkg::PSR_PD_PART16: r = ((a >> `PSR_PART16_LOG2) == '0);
      psr_pkg::PSR_PD_PART32: r = ((a >> `PSR_PART32_LOG2) == '0);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // keep only the enabled lanes of a read word
  function automatic logic [DATA_W-1:0] lane_mask(input logic [DATA_W-1:0] d,
                                                  input logic [1:0] en);
    logic [DATA_W-1:0] m;
    m = {{(DATA_W/2){en[1]}}, {(DATA_W/2){en[0]}}};
    return d & m;
  endfunction

  // ************************************************************
  // phase timer
  // ************************************************************
  psr_timer #(
    .W(`PSR_TMR_W)
  ) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(tmr_load),
    .cycles_i(tmr_cycles),
    .expired_o(tmr_done)
  );

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    pd_opt_next = pd_opt_reg;
    write_next = write_reg;
    latch_next = latch_reg;
    lost_next = lost_reg;
    left_next = left_reg;
    lane_next = lane_reg;
    rsp_valid_next = 1'b0;
    rdata_next = rdata_reg;
    stale_next = stale_reg;
    sel_hi_next = sel_hi_reg;
    cs_n_next = cs_n_reg;
    adv_n_next = adv_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    lane_n_next = lane_n_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    tmr_load = 1'b0;
    tmr_cycles = ONE_CYC;
    case (state_reg)
      psr_pkg::PSR_IDLE:
      begin
        // standby: both selects high, nothing driven
        if (pd_req_i)
        begin
          // power down is entered from standby only
          sel_hi_next = 1'b0;
          pd_opt_next = psr_pkg::psr_pd_opt_t'(pd_option_i);
          lost_next = 1'b1;
          state_next = psr_pkg::PSR_PDOWN;
        end
        else if (req_valid_i && ready_reg)
        begin
          // select with the read and write strobes off, the address strobe low and a valid address first
          cs_n_next = 1'b0;
          addr_next = req_addr_i;
          adv_n_next = `PSR_STROBE_ON;
          lane_n_next = ~req_lane_en_i;
          lane_next = req_lane_en_i;
          write_next = req_write_i;
          latch_next = latch_mode_i;
          left_next = req_write_i ? 3'h0 : req_page_extra_i;
          if (req_write_i)
          begin
            dout_next = req_wdata_i;
            doe_next = req_lane_en_i;
          end
          tmr_load = 1'b1;
          tmr_cycles = ONE_CYC;
          state_next = psr_pkg::PSR_SETUP;
        end
      end
      psr_pkg::PSR_SETUP:
      begin
        // rising strobe latches; staying low keeps pass-through
        adv_n_next = latch_reg ? `PSR_STROBE_OFF : `PSR_STROBE_ON;
        tmr_load = 1'b1;
        if (write_reg)
        begin
          we_n_next = `PSR_STROBE_ON;
          oe_n_next = `PSR_STROBE_OFF;
          tmr_cycles = WP_CYC;
          state_next = psr_pkg::PSR_WRITE;
        end
        else
        begin
          oe_n_next = `PSR_STROBE_ON;
          tmr_cycles = CE_CYC;
          state_next = psr_pkg::PSR_READ;
        end
      end
      psr_pkg::PSR_READ, psr_pkg::PSR_PAGE:
      begin
        // a fresh in-page address must be latched again before use
        if (latch_reg && !adv_n_reg)
        begin
          adv_n_next = `PSR_STROBE_OFF;
        end
        if (tmr_done)
        begin
          rsp_valid_next = 1'b1;
          rdata_next = lane_mask(data_i, lane_reg);
          stale_next = lost_reg && !in_retained(addr_reg, pd_opt_reg);
          if (left_reg == 3'h0)
          begin
            // deselect at once so the part never sits idle-selected
            cs_n_next = 1'b1;
            oe_n_next = `PSR_STROBE_OFF;
            adv_n_next = `PSR_STROBE_OFF;
            lane_n_next = ~`PSR_LANES_NONE;
            tmr_load = 1'b1;
            tmr_cycles = REC_CYC;
            state_next = psr_pkg::PSR_RECOVER;
          end
          else
          begin
            // step only the in-page bits, output strobe stays low
            left_next = left_reg - 3'h1;
            addr_next = {addr_reg[ADDR_W-1:`PSR_PAGE_BITS],
                         addr_reg[`PSR_PAGE_BITS-1:0] + 3'h1};
            adv_n_next = latch_reg ? `PSR_STROBE_ON : adv_n_reg;
            tmr_load = 1'b1;
            tmr_cycles = PAA_CYC + (latch_reg ? ONE_CYC : '0);
            state_next = psr_pkg::PSR_PAGE;
          end
        end
      end
      psr_pkg::PSR_WRITE:
      begin
        // end the pulse and release the bus together
        if (tmr_done)
        begin
          we_n_next = `PSR_STROBE_OFF;
          cs_n_next = 1'b1;
          adv_n_next = `PSR_STROBE_OFF;
          lane_n_next = ~`PSR_LANES_NONE;
          doe_next = `PSR_LANES_NONE;
          tmr_load = 1'b1;
          tmr_cycles = REC_CYC;
          state_next = psr_pkg::PSR_RECOVER;
        end
      end
      psr_pkg::PSR_RECOVER:
      begin
        // deselected gap meets the cycle time before the next access
        if (tmr_done)
        begin
          state_next = psr_pkg::PSR_IDLE;
        end
      end
      psr_pkg::PSR_PDOWN:
      begin
        // data stays released for the whole power down
        doe_next = `PSR_LANES_NONE;
        if (!pd_req_i)
        begin
          sel_hi_next = 1'b1;
          tmr_load = 1'b1;
          tmr_cycles = REC_CYC;
          state_next = psr_pkg::PSR_RECOVER;
        end
      end
      default:
      begin
        state_next = psr_pkg::PSR_IDLE;
      end
    endcase
    ready_next = (state_next == psr_pkg::PSR_IDLE) && !pd_req_i;
    pdn_next = !sel_hi_next;
  end

  // ************************************************************
  // registers
  // ************************************************************
  // reset lands in standby: both selects high, strobes off, bus released
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= psr_pkg::PSR_IDLE;
      pd_opt_reg <= psr_pkg::PSR_PD_SLEEP;
      write_reg <= 1'b0;
      latch_reg <= 1'b0;
      lost_reg <= 1'b0;
      left_reg <= 3'h0;
      lane_reg <= 2'h0;
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rdata_reg <= '0;
      stale_reg <= 1'b0;
      sel_hi_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      adv_n_reg <= `PSR_STROBE_OFF;
      we_n_reg <= `PSR_STROBE_OFF;
      oe_n_reg <= `PSR_STROBE_OFF;
      lane_n_reg <= ~`PSR_LANES_NONE;
      addr_reg <= '0;
      dout_reg <= '0;
      doe_reg <= `PSR_LANES_NONE;
      pdn_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pd_opt_reg <= pd_opt_next;
      write_reg <= write_next;
      latch_reg <= latch_next;
      lost_reg <= lost_next;
      left_reg <= left_next;
      lane_reg <= lane_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rdata_reg <= rdata_next;
      stale_reg <= stale_next;
      sel_hi_reg <= sel_hi_next;
      cs_n_reg <= cs_n_next;
      adv_n_reg <= adv_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      lane_n_reg <= lane_n_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      pdn_reg <= pdn_next;
    end
  end

  // ************************************************************
  // outputs, each straight from a flip-flop
  // ************************************************************
  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_rdata_o = rdata_reg;
  assign rsp_stale_o = stale_reg;
  assign powered_down_o = pdn_reg;
  assign select_high_active_o = sel_hi_reg;
  assign chip_select_n_o = cs_n_reg;
  assign address_valid_strobe_n_o = adv_n_reg;
  assign write_strobe_n_o = we_n_reg;
  assign output_strobe_n_o = oe_n_reg;
  assign upper_lane_enable_n_o = lane_n_reg[1];
  assign lower_lane_enable_n_o = lane_n_reg[0];
  assign word_address_lines_o = addr_reg;
  assign data_o = dout_reg;
  assign data_oe_o = doe_reg;

endmodule

// >>> hdl/psr_map.svh
// timing, geometry and encoding constants for the pseudo-static ram host controller
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// ************************************************************
// clock and access timing
// ************************************************************
`define PSR_CLK_PERIOD_NS 25
`define PSR_T_CE_NS 70
`define PSR_T_PAA_NS 20

// ************************************************************
// array geometry
// ************************************************************
`define PSR_PAGE_BITS 3
`define PSR_PART16_LOG2 20
`define PSR_PART32_LOG2 21
`define PSR_TMR_W 8

// ************************************************************
// pin levels
// ************************************************************
`define PSR_STROBE_OFF 1'b1
`define PSR_STROBE_ON 1'b0
`define PSR_LANES_NONE 2'h0

`endif

// >>> hdl/psr_pkg.sv
// types and shared arithmetic for the pseudo-static ram host controller
`include "psr_map.svh"

package psr_pkg;

  // controller sequencing states
  typedef enum logic [2:0] {
    PSR_IDLE,
    PSR_SETUP,
    PSR_READ,
    PSR_PAGE,
    PSR_WRITE,
    PSR_RECOVER,
    PSR_PDOWN
  } psr_state_t;

  // power-down options the device was configured with
  typedef enum logic [1:0] {
    PSR_PD_SLEEP,
    PSR_PD_PART16,
    PSR_PD_PART32
  } psr_pd_opt_t;

  // least time in ns to whole clock cycles, rounded up, never below one
  function automatic logic [`PSR_TMR_W-1:0] psr_ns_to_cycles(input int ns);
    int c;
    c = (ns + `PSR_CLK_PERIOD_NS - 1) / `PSR_CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[`PSR_TMR_W-1:0];
  endfunction

endpackage

// >>> hdl/psr_timer.sv
// down counter that times each phase of a memory access
`timescale 1ns/1ps

module psr_timer #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [W-1:0] cycles_i,
  output logic expired_o
);

  // ************************************************************
  // counter state
  // ************************************************************
  logic [W-1:0] cnt_reg; // cycles left in the phase, minus one
  logic [W-1:0] cnt_next;

  // a load of n keeps the phase open for exactly n cycles
  always_comb
  begin
    cnt_next = cnt_reg;
    if (load_i)
    begin
      cnt_next = cycles_i - W'(1);
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  // register only
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  // phase ends in the cycle the count reaches zero
  assign expired_o = (cnt_reg == '0);

endmodule
